//--- rtl/gpio_pkg.sv
// Shared constants and types for the bytewise I/O port block
package gpio_pkg;

	// ----------------------------------------------------------------
	// Port indices
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 3;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int PORT_C = 2;

	// ----------------------------------------------------------------
	// Data-space offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_DATA_A = 8'hC0;
	localparam logic [7:0] OFS_DATA_B = 8'hC1;
	localparam logic [7:0] OFS_DATA_C = 8'hC3;
	localparam logic [7:0] OFS_DIR_A = 8'hC4;
	localparam logic [7:0] OFS_DIR_B = 8'hC5;
	localparam logic [7:0] OFS_DIR_C = 8'hC6;
	localparam logic [7:0] OFS_OPT_A = 8'hCC;
	localparam logic [7:0] OFS_OPT_B = 8'hCE;
	localparam logic [7:0] OFS_OPT_C = 8'hCF;

	// ----------------------------------------------------------------
	// Reset values and line masks
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] IMPL_MASK_A = 8'hFC;
	localparam logic [7:0] IMPL_MASK_B = 8'hFF;
	localparam logic [7:0] IMPL_MASK_C = 8'hFF;
	localparam logic [7:0] ANALOG_MASK_A = 8'h00;
	localparam logic [7:0] ANALOG_MASK_B = 8'hFF;
	localparam logic [7:0] ANALOG_MASK_C = 8'hF0;

	// ----------------------------------------------------------------
	// Alternate-function line positions
	// ----------------------------------------------------------------
	localparam int LINE_PWM_OUT = 7;
	localparam int LINE_TIMER_IN = 6;
	localparam int LINE_UART_RX = 1;
	localparam int LINE_UART_TX = 0;
	localparam int LINE_SPI_OUT = 7;
	localparam int LINE_SPI_IN = 6;
	localparam int LINE_SPI_CLK = 5;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_DATA,
		KIND_DIR,
		KIND_OPT
	} reg_kind_t;

	typedef struct packed {
		reg_kind_t kind;
		logic [1:0] port;
	} access_t;

endpackage : gpio_pkg

//--- rtl/pin_sync_byte.sv
// Three-stage synchroniser with agreement filter for one byte of pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync_byte
	import gpio_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] pin,
	output logic [7:0] level
);

	typedef struct packed {
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] level;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// A bit changes only once the second and third stages agree
	always_comb begin
		next_st = st;
		next_st.s1 = pin;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int n = 0; n < 8; n++) begin
			if (st.s2[n] == st.s3[n]) begin
				next_st.level[n] = st.s3[n];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;

endmodule : pin_sync_byte

`default_nettype wire

//--- rtl/gpio_port_block.sv
// Bytewise three-port I/O block with timer, SPI and UART alternates
//
// Summary of operation
// R1: Each port has data, direction and option bytes; bit n steers line n.
// R2: Reading data of an input line returns the live pin level.
// R3: Writing data updates the latch, which drives output lines except as R11, R14 and R16 say.
// R4: Direction 0 makes a line input, 1 makes it output.
// R5: Reset clears all registers: inputs with pull-up, no interrupt.
// R6: Input mode by option/data: pull-up, none, pull-up+interrupt, analog.
// R7: Output: option 0 open-drain, 1 push-pull; data bit is the value.
// R8: Input without pull-up is high impedance, no pull-up, no drive.
// R9: Interrupt-mode lines feed the interrupt system; trigger chosen per port.
// R10: Analog lines connect to the converter mux; select one at a time.
// R11: PWM enable high makes port B line 7 the PWM output.
// R12: Port B line 6 always feeds the reload timer; software makes it input.
// R13: SPI data-in and clock feed the SPI as inputs, still readable.
// R14: SPI data-out transmits only open-drain; push-pull shows the latch.
// R15: UART receive line feeds the receiver as input, still readable.
// R16: UART transmit line shows latch when idle, UART data when sending.
// R17: Software keeps a RAM copy rather than bit operations on data.
// R18: Software masks unimplemented bits on whole-register operations.
// R19: Unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module gpio_port_block
	import gpio_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic [7:0] pin_in_a,
	input wire logic [7:0] pin_in_b,
	input wire logic [7:0] pin_in_c,
	output logic [7:0] pin_out_a,
	output logic [7:0] pin_out_b,
	output logic [7:0] pin_out_c,
	output logic [7:0] pin_oe_a,
	output logic [7:0] pin_oe_b,
	output logic [7:0] pin_oe_c,
	output logic [7:0] pull_up_a,
	output logic [7:0] pull_up_b,
	output logic [7:0] pull_up_c,
	output logic [7:0] int_line_a,
	output logic [7:0] int_line_b,
	output logic [7:0] int_line_c,
	output logic [7:0] irq_level_a,
	output logic [7:0] irq_level_b,
	output logic [7:0] irq_level_c,
	output logic [7:0] analog_sel_b,
	output logic [7:0] analog_sel_c,
	input wire logic timer_pwm_out_enable,
	input wire logic reload_timer_out_pin,
	output logic reload_timer_in_pin,
	output logic spi_data_in,
	output logic spi_clock_in,
	input wire logic spi_data_out,
	output logic uart_receive_line,
	input wire logic uart_tx_active,
	input wire logic uart_transmit_line
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0][7:0] data;
		logic [2:0][7:0] dir;
		logic [2:0][7:0] opt;
		logic [2:0][7:0] pin_out;
		logic [2:0][7:0] pin_oe;
		logic [2:0][7:0] pull_up;
		logic [2:0][7:0] int_en;
		logic [2:0][7:0] irq_level;
		logic [2:0][7:0] analog;
		logic [7:0] rd_data;
		logic timer_in;
		logic spi_din;
		logic spi_clk;
		logic uart_rx;
	} port_state_t;

	port_state_t st;
	port_state_t next_st;
	logic [2:0][7:0] level;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic access_t decode(input logic [7:0] addr);
		access_t a;
		a.kind = KIND_NONE;
		a.port = 2'(PORT_A);
		case (addr)
			OFS_DATA_A: a = '{KIND_DATA, 2'(PORT_A)};
			OFS_DATA_B: a = '{KIND_DATA, 2'(PORT_B)};
			OFS_DATA_C: a = '{KIND_DATA, 2'(PORT_C)};
			OFS_DIR_A: a = '{KIND_DIR, 2'(PORT_A)};
			OFS_DIR_B: a = '{KIND_DIR, 2'(PORT_B)};
			OFS_DIR_C: a = '{KIND_DIR, 2'(PORT_C)};
			OFS_OPT_A: a = '{KIND_OPT, 2'(PORT_A)};
			OFS_OPT_B: a = '{KIND_OPT, 2'(PORT_B)};
			OFS_OPT_C: a = '{KIND_OPT, 2'(PORT_C)};
			default: a.kind = KIND_NONE;
		endcase
		return a;
	endfunction : decode

	function automatic logic [7:0] impl_mask(input logic [1:0] p);
		case (p)
			2'(PORT_A): return IMPL_MASK_A;
			2'(PORT_B): return IMPL_MASK_B;
			default: return IMPL_MASK_C;
		endcase
	endfunction : impl_mask

	function automatic logic [7:0] analog_mask(input logic [1:0] p);
		case (p)
			2'(PORT_A): return ANALOG_MASK_A;
			2'(PORT_B): return ANALOG_MASK_B;
			default: return ANALOG_MASK_C;
		endcase
	endfunction : analog_mask

	// Returns {output enable, output value} for an output line
	function automatic logic [1:0] drive(input logic dir, input logic opt,
			input logic val);
		if (!dir) begin
			return 2'b00;
		end else if (opt) begin
			return {1'b1, val};
		end else begin
			// Open drain: only ever pulls low
			return {~val, 1'b0};
		end
	endfunction : drive

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	pin_sync_byte u_sync_a (
		.clk(clk),
		.rst_n(rst_n),
		.pin(pin_in_a),
		.level(level[PORT_A])
	);

	pin_sync_byte u_sync_b (
		.clk(clk),
		.rst_n(rst_n),
		.pin(pin_in_b),
		.level(level[PORT_B])
	);

	pin_sync_byte u_sync_c (
		.clk(clk),
		.rst_n(rst_n),
		.pin(pin_in_c),
		.level(level[PORT_C])
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		access_t wa;
		access_t ra;
		logic [1:0] dv;
		logic [7:0] m;
		logic [7:0] am;
		logic d;
		logic o;
		logic v;
		next_st = st;
		wa = decode(wr_addr);
		ra = decode(rd_addr);
		dv = 2'b00;
		m = 8'h00;
		am = 8'h00;
		d = 1'b0;
		o = 1'b0;
		v = 1'b0;

		// Register writes; missing lines never store a one
		if (wr_en) begin
			m = impl_mask(wa.port);
			case (wa.kind)
				KIND_DATA: next_st.data[wa.port] = wr_data & m; // R1 R3 R19
				KIND_DIR: next_st.dir[wa.port] = wr_data & m; // R1 R4 R19
				KIND_OPT: next_st.opt[wa.port] = wr_data & m; // R1 R19
				default: next_st.rd_data = st.rd_data;
			endcase
		end

		// Reads: input lines return the pin, output lines the latch
		if (rd_en) begin
			m = impl_mask(ra.port);
			case (ra.kind)
				KIND_DATA: next_st.rd_data = m & ((st.data[ra.port] &
					st.dir[ra.port]) | (level[ra.port] &
					~st.dir[ra.port])); // R2 R13 R15 R19
				KIND_DIR: next_st.rd_data = st.dir[ra.port] & m;
				KIND_OPT: next_st.rd_data = st.opt[ra.port] & m;
				default: next_st.rd_data = 8'h00;
			endcase
		end

		// Per-line pin configuration
		for (int p = 0; p < NUM_PORTS; p++) begin
			m = impl_mask(2'(p));
			am = analog_mask(2'(p));
			for (int n = 0; n < 8; n++) begin
				d = st.dir[p][n];
				o = st.opt[p][n];
				v = st.data[p][n];
				dv = drive(d, o, v); // R3 R4 R7
				if (p == PORT_A && n == LINE_SPI_OUT && d && !o) begin
					// SPI idles high, so the latch should be left at one
					dv = drive(1'b1, 1'b0, v & spi_data_out); // R14
				end
				if (p == PORT_B && n == LINE_UART_TX && d &&
						uart_tx_active) begin
					dv = drive(1'b1, o, uart_transmit_line); // R16
				end
				next_st.pin_oe[p][n] = dv[1] & m[n];
				next_st.pin_out[p][n] = dv[0] & m[n];
				// Mode table: 00 pull-up, 01 float, 10 pull+irq, 11 analog
				next_st.pull_up[p][n] = ~d & ~v & m[n]; // R5 R6 R8
				next_st.int_en[p][n] = ~d & o & ~v & m[n]; // R6 R9
				next_st.analog[p][n] = ~d & o & v & am[n]; // R6 R10
				if (p == PORT_B && n == LINE_PWM_OUT &&
						timer_pwm_out_enable) begin
					next_st.pin_oe[p][n] = 1'b1; // R11
					next_st.pin_out[p][n] = reload_timer_out_pin; // R11
					next_st.pull_up[p][n] = 1'b0;
					next_st.int_en[p][n] = 1'b0;
					next_st.analog[p][n] = 1'b0;
				end
			end
			// Non-interrupt lines sit high so a low-level trigger ignores them
			next_st.irq_level[p] = level[p] | ~next_st.int_en[p]; // R9
		end

		// Peripheral feeds
		next_st.timer_in = level[PORT_B][LINE_TIMER_IN]; // R12
		next_st.spi_din = ~st.dir[PORT_A][LINE_SPI_IN] &
			level[PORT_A][LINE_SPI_IN]; // R13
		next_st.spi_clk = ~st.dir[PORT_A][LINE_SPI_CLK] &
			level[PORT_A][LINE_SPI_CLK]; // R13
		next_st.uart_rx = st.dir[PORT_B][LINE_UART_RX] |
			level[PORT_B][LINE_UART_RX]; // R15
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0; // R5
			st.pull_up[PORT_A] <= IMPL_MASK_A; // R5
			st.pull_up[PORT_B] <= IMPL_MASK_B; // R5
			st.pull_up[PORT_C] <= IMPL_MASK_C; // R5
			st.irq_level <= '1;
			st.uart_rx <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data = st.rd_data;
	assign pin_out_a = st.pin_out[PORT_A];
	assign pin_out_b = st.pin_out[PORT_B];
	assign pin_out_c = st.pin_out[PORT_C];
	assign pin_oe_a = st.pin_oe[PORT_A];
	assign pin_oe_b = st.pin_oe[PORT_B];
	assign pin_oe_c = st.pin_oe[PORT_C];
	assign pull_up_a = st.pull_up[PORT_A];
	assign pull_up_b = st.pull_up[PORT_B];
	assign pull_up_c = st.pull_up[PORT_C];
	assign int_line_a = st.int_en[PORT_A];
	assign int_line_b = st.int_en[PORT_B];
	assign int_line_c = st.int_en[PORT_C];
	assign irq_level_a = st.irq_level[PORT_A];
	assign irq_level_b = st.irq_level[PORT_B];
	assign irq_level_c = st.irq_level[PORT_C];
	assign analog_sel_b = st.analog[PORT_B];
	assign analog_sel_c = st.analog[PORT_C];
	assign reload_timer_in_pin = st.timer_in;
	assign spi_data_in = st.spi_din;
	assign spi_clock_in = st.spi_clk;
	assign uart_receive_line = st.uart_rx;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_write_dir_b;
		wr_en && wr_addr == OFS_DIR_B && !rd_en;
	endsequence

	sequence s_read_dir_b;
		rd_en && rd_addr == OFS_DIR_B && !wr_en;
	endsequence

	property p_dir_roundtrip;
		s_write_dir_b ##1 s_read_dir_b |=> rd_data == $past(wr_data, 2);
	endproperty
	a_dir_roundtrip: assert property (p_dir_roundtrip) // R1
		else $error("direction byte did not read back as written");

	property p_input_reads_pin;
		rd_en && rd_addr == OFS_DATA_C && st.dir[PORT_C] == 8'h00
			|=> rd_data == $past(level[PORT_C]);
	endproperty
	a_input_reads_pin: assert property (p_input_reads_pin) // R2
		else $error("input data read did not return pin level");

	property p_push_pull;
		st.dir[PORT_B][2] && st.opt[PORT_B][2]
			|=> pin_oe_b[2] && pin_out_b[2] == $past(st.data[PORT_B][2]);
	endproperty
	a_push_pull: assert property (p_push_pull) // R3
		else $error("push-pull line does not show latch");

	property p_open_drain;
		st.dir[PORT_C][3] && !st.opt[PORT_C][3]
			|=> !pin_out_c[3] && pin_oe_c[3] == !$past(st.data[PORT_C][3]);
	endproperty
	a_open_drain: assert property (p_open_drain) // R7
		else $error("open-drain line drives wrongly");

	property p_float_input;
		!st.dir[PORT_C][4] && !st.opt[PORT_C][4] && st.data[PORT_C][4]
			|=> !pull_up_c[4] && !pin_oe_c[4] && !int_line_c[4];
	endproperty
	a_float_input: assert property (p_float_input) // R8
		else $error("floating input has pull-up or drive");

	property p_int_input;
		!st.dir[PORT_B][3] && st.opt[PORT_B][3] && !st.data[PORT_B][3]
			|=> int_line_b[3] && pull_up_b[3] && !analog_sel_b[3];
	endproperty
	a_int_input: assert property (p_int_input) // R6
		else $error("interrupt input mode not selected");

	property p_analog_avail;
		!st.dir[PORT_C][2] && st.opt[PORT_C][2] && st.data[PORT_C][2]
			|=> !analog_sel_c[2] && !pull_up_c[2];
	endproperty
	a_analog_avail: assert property (p_analog_avail) // R10
		else $error("analog selected on a line without converter input");

	property p_pwm_takeover;
		timer_pwm_out_enable
			|=> pin_oe_b[7] && pin_out_b[7] == $past(reload_timer_out_pin);
	endproperty
	a_pwm_takeover: assert property (p_pwm_takeover) // R11
		else $error("PWM did not take over port B line 7");

	property p_timer_feed;
		reload_timer_in_pin == $past(level[PORT_B][LINE_TIMER_IN]);
	endproperty
	a_timer_feed: assert property (p_timer_feed) // R12
		else $error("reload timer input not fed from line 6");

	property p_uart_tx;
		st.dir[PORT_B][0] && st.opt[PORT_B][0] && uart_tx_active
			|=> pin_out_b[0] == $past(uart_transmit_line);
	endproperty
	a_uart_tx: assert property (p_uart_tx) // R16
		else $error("UART transmit data not on line 0");

	property p_missing_bits;
		rd_en && rd_addr == OFS_DATA_A |=> rd_data[1:0] == 2'b00;
	endproperty
	a_missing_bits: assert property (p_missing_bits) // R19
		else $error("unimplemented port A bits read non-zero");

endmodule : gpio_port_block

`default_nettype wire

//--- bench/pin_world_model.sv
// Pin-side model: resolves each line from chip drive, pull-up and board drive
`timescale 1ns/1ps
`default_nettype none

module pin_world_model (
	input wire logic clk,
	input wire logic [7:0] drive_out,
	input wire logic [7:0] drive_en,
	input wire logic [7:0] pull_en,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] level
);
	// A floating line toggles every cycle, so no read of it matches by luck
	logic [7:0] wobble = 8'h55;

	always @(posedge clk) begin
		wobble <= ~wobble;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (drive_en[i]) begin
				level[i] = drive_out[i];
			end else if (ext_en[i]) begin
				level[i] = ext_val[i];
			end else if (pull_en[i]) begin
				level[i] = 1'b1;
			end else begin
				level[i] = wobble[i];
			end
		end
	end
endmodule : pin_world_model
`default_nettype wire

//--- bench/byte_wide_io_port_with_alternates_tb_top.sv
// Self-checking bench for the three-port I/O block
`timescale 1ns/1ps
`default_nettype none

module byte_wide_io_port_with_alternates_tb_top
	import gpio_pkg::*;
;
	logic clk, rst_n, wr_en, rd_en;
	logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
	logic [7:0] pin_in_a, pin_in_b, pin_in_c, pin_out_a, pin_out_b, pin_out_c;
	logic [7:0] pin_oe_a, pin_oe_b, pin_oe_c, pull_up_a, pull_up_b, pull_up_c;
	logic [7:0] int_line_a, int_line_b, int_line_c, analog_sel_b, analog_sel_c;
	logic [7:0] irq_level_a, irq_level_b, irq_level_c;
	logic [7:0] ext_en_a, ext_en_b, ext_en_c, ext_val_a, ext_val_b, ext_val_c;
	logic timer_pwm_out_enable, reload_timer_out_pin, reload_timer_in_pin;
	logic spi_data_in, spi_clock_in, spi_data_out;
	logic uart_receive_line, uart_tx_active, uart_transmit_line;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] ctl [6] = '{OFS_DIR_A, OFS_DIR_B, OFS_DIR_C,
		OFS_OPT_A, OFS_OPT_B, OFS_OPT_C};

	gpio_port_block gpio_port_block_i (.clk, .rst_n, .wr_en, .wr_addr,
		.wr_data, .rd_en, .rd_addr, .rd_data, .pin_in_a, .pin_in_b,
		.pin_in_c, .pin_out_a, .pin_out_b, .pin_out_c, .pin_oe_a, .pin_oe_b,
		.pin_oe_c, .pull_up_a, .pull_up_b, .pull_up_c, .int_line_a,
		.int_line_b, .int_line_c, .irq_level_a, .irq_level_b, .irq_level_c,
		.analog_sel_b, .analog_sel_c, .timer_pwm_out_enable,
		.reload_timer_out_pin, .reload_timer_in_pin, .spi_data_in,
		.spi_clock_in, .spi_data_out, .uart_receive_line, .uart_tx_active,
		.uart_transmit_line);

	pin_world_model pins_a (.clk, .drive_out(pin_out_a), .drive_en(pin_oe_a),
		.pull_en(pull_up_a), .ext_en(ext_en_a), .ext_val(ext_val_a),
		.level(pin_in_a));
	pin_world_model pins_b (.clk, .drive_out(pin_out_b), .drive_en(pin_oe_b),
		.pull_en(pull_up_b), .ext_en(ext_en_b), .ext_val(ext_val_b),
		.level(pin_in_b));
	pin_world_model pins_c (.clk, .drive_out(pin_out_c), .drive_en(pin_oe_c),
		.pull_en(pull_up_c), .ext_en(ext_en_c), .ext_val(ext_val_c),
		.level(pin_in_c));

	// ----------------------------------------------------------------
	// Access and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// Read data lands on the edge after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, e);
	endtask : rd

	// Pin inputs need several edges to pass the agreement filter
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic complete_run;
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{wr_en, rd_en, wr_addr, wr_data, rd_addr} = '0;
		{ext_en_a, ext_en_b, ext_en_c} = '0;
		{ext_val_a, ext_val_b, ext_val_c} = '0;
		{timer_pwm_out_enable, reload_timer_out_pin, spi_data_out} = '0;
		{uart_tx_active, uart_transmit_line} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		settle(8);
		chk(pull_up_a, 8'hFC);
		chk(pull_up_b, 8'hFF);
		chk(pin_oe_c, 8'h00);
		chk(int_line_c, 8'h00);
		foreach (ctl[i]) rd(ctl[i], REG_RESET);
		rd(OFS_DATA_B, 8'hFF);
		wr(8'hC2, 8'h5A);
		rd(8'hC2, 8'h00);
		wr(OFS_DIR_A, 8'hFF);
		rd(OFS_DIR_A, 8'hFC);
		wr(OFS_OPT_A, 8'hFF);
		wr(OFS_DATA_A, 8'h80);
		settle(2);
		chk(pin_oe_a, 8'hFC);
		chk(pin_out_a, 8'h80);
		rd(OFS_DATA_A, 8'h80);
		wr(OFS_OPT_A, 8'h00);
		settle(2);
		chk(pin_oe_a, 8'hFC);
		chk(pin_out_a, 8'h00);
		@(posedge clk);
		spi_data_out <= 1'b1;
		settle(2);
		chk(pin_oe_a, 8'h7C);
		// Port A back to inputs: SPI data in low, clock high
		wr(OFS_DIR_A, 8'h00);
		wr(OFS_DATA_A, 8'h00);
		ext_en_a <= 8'h60;
		ext_val_a <= 8'h20;
		settle(8);
		chk({7'h00, spi_data_in}, 8'h00);
		chk({7'h00, spi_clock_in}, 8'h01);
		rd(OFS_DATA_A, 8'hBC);
		chk(rd_data & IMPL_MASK_A, 8'hBC);
		// Port C: one line per mode of the selection table
		wr(OFS_DIR_C, 8'hE0);
		wr(OFS_OPT_C, 8'h9C);
		wr(OFS_DATA_C, 8'hDA);
		ext_en_c <= 8'h1A;
		ext_val_c <= 8'h08;
		settle(8);
		chk(pin_oe_c, 8'hA0);
		chk(pin_out_c, 8'h80);
		chk(pull_up_c, 8'h05);
		chk(int_line_c, 8'h04);
		chk(analog_sel_c, 8'h10);
		chk(irq_level_c, 8'hFF);
		rd(OFS_DATA_C, 8'hCD);
		rd(OFS_OPT_C, 8'h9C);
		@(posedge clk);
		ext_en_c <= 8'h1E;
		settle(8);
		chk(irq_level_c, 8'hFB);
		// Port B: line 0 push-pull, the rest pulled-up inputs
		wr(OFS_DIR_B, 8'h01);
		wr(OFS_OPT_B, 8'h01);
		wr(OFS_DATA_B, 8'h01);
		ext_en_b <= 8'h42;
		ext_val_b <= 8'h00;
		settle(8);
		chk(pin_out_b, 8'h01);
		chk(pin_oe_b, 8'h01);
		chk({7'h00, uart_receive_line}, 8'h00);
		chk({7'h00, reload_timer_in_pin}, 8'h00);
		chk(analog_sel_b, 8'h00);
		chk(int_line_b, 8'h00);
		chk(irq_level_b, 8'hFF);
		rd(OFS_DATA_B, 8'hBD);
		@(posedge clk);
		uart_tx_active <= 1'b1;
		settle(2);
		chk(pin_out_b, 8'h00);
		@(posedge clk);
		uart_tx_active <= 1'b0;
		timer_pwm_out_enable <= 1'b1;
		reload_timer_out_pin <= 1'b1;
		ext_en_b <= 8'h02;
		settle(8);
		chk(pin_out_b, 8'h81);
		chk(pin_oe_b, 8'h81);
		chk(pull_up_b, 8'h7E);
		chk({7'h00, reload_timer_in_pin}, 8'h01);
		@(posedge clk);
		reload_timer_out_pin <= 1'b0;
		settle(2);
		chk(pin_out_b, 8'h01);
		@(posedge clk);
		timer_pwm_out_enable <= 1'b0;
		settle(2);
		chk(pin_oe_b, 8'h01);
		chk(pull_up_b, 8'hFE);
		// Second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		settle(2);
		rst_n <= 1'b1;
		rd(OFS_DIR_C, REG_RESET);
		rd(OFS_OPT_C, REG_RESET);
		complete_run();
	end
endmodule : byte_wide_io_port_with_alternates_tb_top
`default_nettype wire
